// [hdl/drive_status_reply.sv]
// Drive status word, monitor reads and exception replies.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Run state field reads 10 when ready, 11 while operating.
// - Direction bits 3-4: 00 fwd/fwd, 01 fwd/rev, 10 rev/rev.
// - Bit 8 set when frequency reference comes from the serial link.
// - Bit 9 set when frequency reference comes from analog or terminals.
// - Bit 10 set when run and stop commands come from the link.
// - Bit 11 set while parameters are locked.
// - Bit 12 set when keypad copy is enabled; bits 13-15 reserved.
// - Frames with a communication error are dropped with no reply.
// - Good frames that cannot be served get an exception reply.
// - An exception reply shows its code in decimal on the keypad.
// - Exception reply echoes function with top bit set, then code.
// - ASCII exception: start, address, function, code, LRC, CR, LF.
// - Codes: 01 function, 02 address, 03 value, 04 device failure.
// - Bus silence beyond the set interval flags fault 10.
// - Reply waits the set delay in 0.1 ms steps before sending.
// - Binary checksum goes out low byte first, then high byte.
module drive_status_reply #(
	parameter int REPLY_DELAY_CYCLES =
		drive_reply_pkg::REPLY_DELAY_UNIT_CYCLES,
	parameter int SILENCE_CYCLES = drive_reply_pkg::SILENCE_UNIT_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire drive_reply_pkg::request_t req,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic rx_activity,
	input wire drive_reply_pkg::drive_state_t drive_state,
	input wire drive_reply_pkg::monitor_t monitor,
	input wire logic monitor_fault,
	input wire logic [10:0] reply_delay_setting,
	input wire logic [7:0] bus_silence_interval_setting,
	output logic [7:0] tx_byte,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] comm_fault_display_code,
	output logic comm_fault_active,
	input wire logic keypad_clear
);
	import drive_reply_pkg::*;

	if (REPLY_DELAY_CYCLES < 1 || SILENCE_CYCLES < 1) begin : g_bad_counts
		$error("Prescaler counts must be at least one.");
	end

	function automatic logic [15:0] crc_step(input logic [15:0] c,
		input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	function automatic logic [7:0] hex_char(input logic [3:0] n);
		return (n < 4'hA) ? (CHAR_ZERO + {4'h0, n}) :
			(CHAR_A_MINUS_10 + {4'h0, n});
	endfunction

	logic rst_meta_reg;
	logic rst_sync_reg;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	logic [15:0] status_word;
	logic [1:0] run_field;
	logic [1:0] dir_field;
	always_comb begin
		if (drive_state.running)
			run_field = RUN_OPERATING;
		else if (drive_state.ready)
			run_field = RUN_READY;
		else
			run_field = RUN_IDLE;
		if (drive_state.cmd_reverse)
			dir_field = DIR_REV_REV;
		else if (drive_state.out_reverse)
			dir_field = DIR_FWD_REV;
		else
			dir_field = DIR_FWD_FWD;
		status_word = {3'h0,
			drive_state.keypad_copy_en,
			drive_state.params_locked,
			drive_state.oper_from_comm,
			drive_state.freq_from_ext,
			drive_state.freq_from_comm,
			3'h0, dir_field, drive_state.jog, run_field};
	end

	// Decode happens in the accept cycle so the reply reflects that instant.
	logic mapped;
	logic [15:0] read_word;
	logic [7:0] exc_code;
	always_comb begin
		mapped = 1'b1;
		unique case (req.reg_addr)
			ADDR_FREQ_CMD: read_word = monitor.frequency_command_value;
			ADDR_OUT_CURRENT: read_word = monitor.output_current_value;
			ADDR_BUS_VOLTAGE: read_word = monitor.bus_voltage_value;
			ADDR_OUT_VOLTAGE: read_word = monitor.output_voltage_value;
			ADDR_SPEED_STEP: read_word = monitor.speed_step_number;
			ADDR_SEL_DISPLAY: read_word = monitor.selectable_display_value;
			ADDR_STATUS: read_word = status_word;
			ADDR_SWITCH_TEMP: read_word = monitor.power_switch_temperature;
			ADDR_SINK_TEMP: read_word = monitor.heatsink_temperature;
			ADDR_DOUT_STATE: read_word = monitor.digital_output_state;
			default: begin
				read_word = 16'h0000;
				mapped = 1'b0;
			end
		endcase
		exc_code = 8'h00;
		if (req.func == FUNC_READ) begin
			if (req.value != READ_WORD_COUNT)
				exc_code = EXC_ILLEGAL_VALUE;
			else if (!mapped)
				exc_code = EXC_ILLEGAL_ADDR;
			else if (monitor_fault)
				exc_code = EXC_DEVICE_FAIL;
		end else if (req.func == FUNC_WRITE) begin
			exc_code = EXC_ILLEGAL_ADDR;
		end else begin
			exc_code = EXC_ILLEGAL_FUNC;
		end
	end

	reply_state_t state_reg, state_next;
	logic [2:0] idx_reg, idx_next;
	logic [2:0] len_reg, len_next;
	logic nib_reg, nib_next;
	logic ascii_reg, ascii_next;
	logic [15:0] crc_reg, crc_next;
	logic [7:0] lrc_reg, lrc_next;
	logic [7:0] pay_reg [0:4];
	logic [7:0] pay_next [0:4];
	logic [10:0] dly_reg, dly_next;
	logic [31:0] pre_reg, pre_next;
	logic [7:0] tx_byte_reg, tx_byte_next;
	logic tx_valid_reg, tx_valid_next;
	logic [7:0] code_reg, code_next;
	logic fault_reg, fault_next;
	logic [31:0] sil_pre_reg, sil_pre_next;
	logic [7:0] sil_cnt_reg, sil_cnt_next;
	logic sil_hit_reg, sil_hit_next;

	logic slot;
	logic emit;
	logic [7:0] ch;
	logic [7:0] cur;
	logic [7:0] lrc_final;
	logic accept;
	logic exc_set;

	assign req_ready = (state_reg == ST_IDLE);
	assign accept = req_valid && req_ready;
	assign slot = !tx_valid_reg || tx_ready;
	assign cur = pay_reg[idx_reg];
	assign lrc_final = 8'h00 - lrc_reg;

	always_comb begin
		state_next = state_reg;
		idx_next = idx_reg;
		len_next = len_reg;
		nib_next = nib_reg;
		ascii_next = ascii_reg;
		crc_next = crc_reg;
		lrc_next = lrc_reg;
		pay_next = pay_reg;
		dly_next = dly_reg;
		pre_next = pre_reg;
		emit = 1'b0;
		ch = 8'h00;
		exc_set = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				// A corrupted frame is taken and forgotten.
				if (accept && !req.comm_error) begin
					ascii_next = req.ascii;
					idx_next = 3'h0;
					nib_next = 1'b0;
					crc_next = CRC_INIT;
					lrc_next = 8'h00;
					dly_next = reply_delay_setting;
					pre_next = 32'h0;
					pay_next[0] = req.station;
					state_next = ST_WAIT;
					if (exc_code != 8'h00) begin
						pay_next[1] = req.func | FUNC_EXC_FLAG;
						pay_next[2] = exc_code;
						len_next = LEN_EXCEPTION;
						exc_set = 1'b1;
					end else begin
						pay_next[1] = req.func;
						pay_next[2] = READ_BYTE_COUNT;
						pay_next[3] = read_word[15:8];
						pay_next[4] = read_word[7:0];
						len_next = LEN_NORMAL;
					end
				end
			end
			ST_WAIT: begin
				if (dly_reg == 11'h000) begin
					state_next = ascii_reg ? ST_START : ST_BODY;
				end else if (pre_reg == 32'(REPLY_DELAY_CYCLES - 1)) begin
					pre_next = 32'h0;
					dly_next = dly_reg - 11'h001;
				end else begin
					pre_next = pre_reg + 32'h1;
				end
			end
			ST_START: begin
				emit = 1'b1;
				ch = CHAR_START;
				if (slot)
					state_next = ST_BODY;
			end
			ST_BODY: begin
				emit = 1'b1;
				if (ascii_reg)
					ch = hex_char(nib_reg ? cur[3:0] : cur[7:4]);
				else
					ch = cur;
				if (slot) begin
					if (ascii_reg && !nib_reg) begin
						nib_next = 1'b1;
					end else begin
						nib_next = 1'b0;
						crc_next = crc_step(crc_reg, cur);
						lrc_next = lrc_reg + cur;
						idx_next = idx_reg + 3'h1;
						if (idx_reg == len_reg - 3'h1)
							state_next = ST_CHECK;
					end
				end
			end
			ST_CHECK: begin
				emit = 1'b1;
				if (ascii_reg)
					ch = hex_char(nib_reg ? lrc_final[3:0] :
						lrc_final[7:4]);
				else
					ch = nib_reg ? crc_reg[15:8] : crc_reg[7:0];
				if (slot) begin
					nib_next = !nib_reg;
					if (nib_reg)
						state_next = ascii_reg ? ST_TAIL : ST_IDLE;
				end
			end
			ST_TAIL: begin
				emit = 1'b1;
				ch = nib_reg ? CHAR_LF : CHAR_CR;
				if (slot) begin
					nib_next = !nib_reg;
					if (nib_reg)
						state_next = ST_IDLE;
				end
			end
		endcase
	end

	// One-deep output stage keeps the byte lane on a flip-flop.
	always_comb begin
		tx_valid_next = tx_valid_reg;
		tx_byte_next = tx_byte_reg;
		if (slot) begin
			tx_valid_next = emit;
			if (emit)
				tx_byte_next = ch;
		end
	end

	// Silence is counted in whole intervals; a zero setting disables it.
	always_comb begin
		sil_pre_next = sil_pre_reg;
		sil_cnt_next = sil_cnt_reg;
		sil_hit_next = 1'b0;
		if (rx_activity || req_valid || bus_silence_interval_setting == 8'h00
			|| sil_cnt_reg == bus_silence_interval_setting) begin
			sil_pre_next = 32'h0;
			if (rx_activity || req_valid
				|| bus_silence_interval_setting == 8'h00)
				sil_cnt_next = 8'h00;
		end else if (sil_pre_reg == 32'(SILENCE_CYCLES - 1)) begin
			sil_pre_next = 32'h0;
			sil_cnt_next = sil_cnt_reg + 8'h01;
			if (sil_cnt_reg + 8'h01 == bus_silence_interval_setting)
				sil_hit_next = 1'b1;
		end else begin
			sil_pre_next = sil_pre_reg + 32'h1;
		end
	end

	// A new fault wins over a keypad clear in the same cycle.
	always_comb begin
		code_next = code_reg;
		fault_next = fault_reg;
		if (keypad_clear)
			fault_next = 1'b0;
		if (sil_hit_reg) begin
			code_next = BUS_SILENCE_FAULT_CODE;
			fault_next = 1'b1;
		end
		if (exc_set) begin
			code_next = exc_code;
			fault_next = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			state_reg <= ST_IDLE;
			idx_reg <= 3'h0;
			len_reg <= 3'h0;
			nib_reg <= 1'b0;
			ascii_reg <= 1'b0;
			crc_reg <= CRC_INIT;
			lrc_reg <= 8'h00;
			for (int i = 0; i < 5; i++)
				pay_reg[i] <= 8'h00;
			dly_reg <= 11'h000;
			pre_reg <= 32'h0;
			tx_byte_reg <= 8'h00;
			tx_valid_reg <= 1'b0;
			code_reg <= 8'h00;
			fault_reg <= 1'b0;
			sil_pre_reg <= 32'h0;
			sil_cnt_reg <= 8'h00;
			sil_hit_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			idx_reg <= idx_next;
			len_reg <= len_next;
			nib_reg <= nib_next;
			ascii_reg <= ascii_next;
			crc_reg <= crc_next;
			lrc_reg <= lrc_next;
			pay_reg <= pay_next;
			dly_reg <= dly_next;
			pre_reg <= pre_next;
			tx_byte_reg <= tx_byte_next;
			tx_valid_reg <= tx_valid_next;
			code_reg <= code_next;
			fault_reg <= fault_next;
			sil_pre_reg <= sil_pre_next;
			sil_cnt_reg <= sil_cnt_next;
			sil_hit_reg <= sil_hit_next;
		end
	end

	assign tx_byte = tx_byte_reg;
	assign tx_valid = tx_valid_reg;
	assign comm_fault_display_code = code_reg;
	assign comm_fault_active = fault_reg;
endmodule

`default_nettype wire

// [shared/drive_reply_pkg.sv]
// Shared constants and carrier types for the drive reply block.
package drive_reply_pkg;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int REPLY_DELAY_UNIT_PS = 100_000_000;
	// The silence unit is held in nanoseconds, since picoseconds overflow.
	localparam int SILENCE_UNIT_NS = 100_000_000;
	localparam int REPLY_DELAY_UNIT_CYCLES = REPLY_DELAY_UNIT_PS / CLK_PERIOD_PS;
	localparam int SILENCE_UNIT_CYCLES =
		SILENCE_UNIT_NS / (CLK_PERIOD_PS / 1000);

	localparam logic [15:0] ADDR_FREQ_CMD = 16'h2102;
	localparam logic [15:0] ADDR_OUT_CURRENT = 16'h2103;
	localparam logic [15:0] ADDR_BUS_VOLTAGE = 16'h2104;
	localparam logic [15:0] ADDR_OUT_VOLTAGE = 16'h2105;
	localparam logic [15:0] ADDR_SPEED_STEP = 16'h2107;
	localparam logic [15:0] ADDR_SEL_DISPLAY = 16'h2116;
	localparam logic [15:0] ADDR_STATUS = 16'h2119;
	localparam logic [15:0] ADDR_SWITCH_TEMP = 16'h2206;
	localparam logic [15:0] ADDR_SINK_TEMP = 16'h2207;
	localparam logic [15:0] ADDR_DOUT_STATE = 16'h2209;

	localparam logic [7:0] FUNC_READ = 8'h03;
	localparam logic [7:0] FUNC_WRITE = 8'h06;
	localparam logic [7:0] FUNC_EXC_FLAG = 8'h80;
	localparam logic [7:0] READ_BYTE_COUNT = 8'h02;
	localparam logic [15:0] READ_WORD_COUNT = 16'h0001;

	localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
	localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
	localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
	localparam logic [7:0] EXC_DEVICE_FAIL = 8'h04;
	localparam logic [7:0] BUS_SILENCE_FAULT_CODE = 8'h10;

	localparam logic [1:0] RUN_IDLE = 2'h0;
	localparam logic [1:0] RUN_READY = 2'h2;
	localparam logic [1:0] RUN_OPERATING = 2'h3;
	localparam logic [1:0] DIR_FWD_FWD = 2'h0;
	localparam logic [1:0] DIR_FWD_REV = 2'h1;
	localparam logic [1:0] DIR_REV_REV = 2'h2;

	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;
	localparam logic [7:0] CHAR_START = 8'h3A;
	localparam logic [7:0] CHAR_CR = 8'h0D;
	localparam logic [7:0] CHAR_LF = 8'h0A;
	localparam logic [7:0] CHAR_ZERO = 8'h30;
	localparam logic [7:0] CHAR_A_MINUS_10 = 8'h37;
	localparam logic [2:0] LEN_NORMAL = 3'h5;
	localparam logic [2:0] LEN_EXCEPTION = 3'h3;

	typedef struct packed {
		logic [7:0] station;
		logic [7:0] func;
		logic [15:0] reg_addr;
		logic [15:0] value;
		logic comm_error;
		logic ascii;
	} request_t;

	typedef struct packed {
		logic ready;
		logic running;
		logic jog;
		logic cmd_reverse;
		logic out_reverse;
		logic freq_from_comm;
		logic freq_from_ext;
		logic oper_from_comm;
		logic params_locked;
		logic keypad_copy_en;
	} drive_state_t;

	typedef struct packed {
		logic [15:0] frequency_command_value;
		logic [15:0] output_current_value;
		logic [15:0] bus_voltage_value;
		logic [15:0] output_voltage_value;
		logic [15:0] speed_step_number;
		logic [15:0] selectable_display_value;
		logic [15:0] power_switch_temperature;
		logic [15:0] heatsink_temperature;
		logic [15:0] digital_output_state;
	} monitor_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_WAIT = 3'h1,
		ST_START = 3'h3,
		ST_BODY = 3'h2,
		ST_CHECK = 3'h6,
		ST_TAIL = 3'h7
	} reply_state_t;
endpackage

// [tb/bus_master_model.sv]
// Serial master stand-in that collects reply bytes, stalling on request.
`timescale 1ns/10ps
`default_nettype none
module bus_master_model (
	input wire logic sys_clk,
	input wire logic [7:0] tx_byte,
	input wire logic tx_valid,
	input wire logic slow,
	output logic tx_ready
);
	logic [7:0] got[$];
	logic ph;
	initial begin
		tx_ready = 1'b1;
		ph = 1'b0;
	end
	// Arrival order is kept so the bench sees the byte order on the line.
	always @(posedge sys_clk)
		if (tx_valid && tx_ready)
			got.push_back(tx_byte);
	always @(negedge sys_clk) begin
		ph = !ph;
		tx_ready = !slow || ph;
	end
endmodule
`default_nettype wire

// [tb/drive_status_reply_monitor.sv]
// Port assertions for the status and exception reply block.
`timescale 1ns/10ps
`default_nettype none
module drive_status_reply_monitor #(
	parameter int REPLY_DELAY_CYCLES = 4,
	parameter int SILENCE_CYCLES = 8
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire drive_reply_pkg::request_t req,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic rx_activity,
	input wire logic [10:0] reply_delay_setting,
	input wire logic [7:0] bus_silence_interval_setting,
	input wire logic [7:0] tx_byte,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [7:0] comm_fault_display_code,
	input wire logic comm_fault_active,
	input wire logic keypad_clear
);
	import drive_reply_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	logic take;
	logic [15:0] quiet_reg;
	logic [15:0] quiet_next;
	assign take = req_valid && req_ready && !req.comm_error;
	// A clear saturates the count, since one silence flags only once.
	always_comb begin
		quiet_next = quiet_reg;
		if (rx_activity || req_valid || bus_silence_interval_setting != 8'h01)
			quiet_next = 16'h0000;
		else if (keypad_clear)
			quiet_next = 16'(SILENCE_CYCLES + 4);
		else if (quiet_reg < 16'(SILENCE_CYCLES + 4))
			quiet_next = quiet_reg + 16'h0001;
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			quiet_reg <= 16'h0000;
		else
			quiet_reg <= quiet_next;
	end
	lane_hold_a: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
		else $error("reply byte changed before it was taken");
	busy_ready_a: assert property (take |=> !req_ready)
		else $error("request taken while a reply is pending");
	drop_frame_a: assert property (
		req_valid && req_ready && req.comm_error && !tx_valid
		|=> !tx_valid [*2]) else $error("reply sent for a corrupt frame");
	write_code_a: assert property (take && req.func == 8'h06
		|=> comm_fault_active && comm_fault_display_code == 8'h02)
		else $error("write not flagged with code 02");
	func_code_a: assert property (
		take && req.func != 8'h03 && req.func != 8'h06
		|=> comm_fault_active && comm_fault_display_code == 8'h01)
		else $error("unknown function not flagged with code 01");
	answer_time_a: assert property (
		take && reply_delay_setting == 11'h000 |-> ##3 tx_valid)
		else $error("reply late with no delay set");
	delay_wait_a: assert property (
		take && reply_delay_setting == 11'h001 && !tx_valid
		&& REPLY_DELAY_CYCLES == 4 |=> !tx_valid [*6] ##1 tx_valid)
		else $error("reply delay of one unit not kept");
	clear_fault_a: assert property (
		keypad_clear && req_ready && !req_valid
		&& bus_silence_interval_setting == 8'h00 |=> !comm_fault_active)
		else $error("fault display not cleared");
	silence_a: assert property (
		quiet_reg == 16'(SILENCE_CYCLES + 3)
		|-> comm_fault_active && comm_fault_display_code == 8'h10)
		else $error("bus silence not flagged");
	cover property (take && req.ascii);
	cover property (take && req.func == 8'h03);
	cover property (tx_valid && !tx_ready);
endmodule
bind drive_status_reply drive_status_reply_monitor #(
	.REPLY_DELAY_CYCLES(REPLY_DELAY_CYCLES),
	.SILENCE_CYCLES(SILENCE_CYCLES)
) mon (.sys_clk, .rst_n, .req, .req_valid, .req_ready, .rx_activity,
	.reply_delay_setting, .bus_silence_interval_setting, .tx_byte,
	.tx_valid, .tx_ready, .comm_fault_display_code, .comm_fault_active,
	.keypad_clear);
`default_nettype wire

// [tb/tb_drive_status_reply.sv]
// Self-checking bench for the status and exception reply block.
`timescale 1ns/10ps
`default_nettype none
module tb_drive_status_reply;
	import drive_reply_pkg::*;
	typedef logic [7:0] bq_t[$];
	logic sys_clk, rst_n, req_valid, req_ready, rx_activity, monitor_fault;
	logic tx_valid, tx_ready, comm_fault_active, keypad_clear, slow;
	logic [10:0] reply_delay_setting;
	logic [7:0] bus_silence_interval_setting, tx_byte;
	logic [7:0] comm_fault_display_code;
	request_t req;
	drive_state_t drive_state;
	monitor_t monitor;
	logic [31:0] seed;
	int failures, num_checks;
	logic [15:0] maddr[9] = '{16'h2102, 16'h2103, 16'h2104, 16'h2105,
		16'h2107, 16'h2116, 16'h2206, 16'h2207, 16'h2209};
	drive_status_reply #(.REPLY_DELAY_CYCLES(4), .SILENCE_CYCLES(8)) dut (
		.sys_clk, .rst_n, .req, .req_valid, .req_ready, .rx_activity,
		.drive_state, .monitor, .monitor_fault, .reply_delay_setting,
		.bus_silence_interval_setting, .tx_byte, .tx_valid, .tx_ready,
		.comm_fault_display_code, .comm_fault_active, .keypad_clear);
	bus_master_model master (.sys_clk, .tx_byte, .tx_valid, .slow,
		.tx_ready);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] hx(input logic [3:0] n);
		return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
	endfunction
	function automatic bq_t frame(input bq_t p, input logic asc);
		bq_t f;
		logic [15:0] c;
		logic [7:0] s;
		c = 16'hFFFF;
		s = 8'h00;
		foreach (p[i]) begin
			s = s + p[i];
			c = c ^ {8'h00, p[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		if (!asc)
			return {p, c[7:0], c[15:8]};
		p.push_back(8'h00 - s);
		f = {8'h3A};
		foreach (p[i]) f = {f, hx(p[i][7:4]), hx(p[i][3:0])};
		return {f, 8'h0D, 8'h0A};
	endfunction
	function automatic logic [15:0] status(input drive_state_t d);
		logic [15:0] w;
		w = 16'h0000;
		w[1:0] = d.running ? 2'h3 : (d.ready ? 2'h2 : 2'h0);
		w[2] = d.jog;
		w[4:3] = d.cmd_reverse ? 2'h2 : {1'b0, d.out_reverse};
		w[12:8] = {d.keypad_copy_en, d.params_locked, d.oper_from_comm,
			d.freq_from_ext, d.freq_from_comm};
		return w;
	endfunction
	// Expected exception code, zero where a normal reply is due.
	function automatic logic [7:0] exc(input request_t r,
		output logic [15:0] w);
		logic hit;
		w = status(drive_state);
		hit = (r.reg_addr == 16'h2119);
		if (r.func == 8'h06)
			return 8'h02;
		if (r.func != 8'h03)
			return 8'h01;
		if (r.value != 16'h0001)
			return 8'h03;
		foreach (maddr[i]) if (r.reg_addr == maddr[i]) begin
			hit = 1'b1;
			w = monitor[143 - 16 * i -: 16];
		end
		if (!hit)
			return 8'h02;
		return monitor_fault ? 8'h04 : 8'h00;
	endfunction
	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic results();
		$display("checks %0d, mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic transact(input request_t r);
		logic [15:0] w;
		logic [7:0] code;
		bq_t p, want;
		int n;
		code = exc(r, w);
		if (code != 8'h00)
			p = {r.station, r.func | 8'h80, code};
		else
			p = {r.station, 8'h03, 8'h02, w[15:8], w[7:0]};
		want = frame(p, r.ascii);
		if (r.comm_error)
			want.delete();
		master.got.delete();
		req = r;
		req_valid = 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (!req_ready && n < 100);
		@(negedge sys_clk);
		req_valid = 1'b0;
		repeat (30) @(negedge sys_clk);
		for (n = 0; master.got.size() < want.size() && n < 2000; n++)
			@(negedge sys_clk);
		repeat (4) @(negedge sys_clk);
		check("reply length", 16'(want.size()), 16'(master.got.size()));
		foreach (want[i]) if (i < master.got.size())
			check("reply byte", want[i], master.got[i]);
		if (r.comm_error || code == 8'h00)
			check("fault shown", 16'h0000, comm_fault_active);
		else begin
			check("fault code", code, comm_fault_display_code);
			check("fault shown", 16'h0001, comm_fault_active);
			keypad_clear = 1'b1;
			@(negedge sys_clk);
			keypad_clear = 1'b0;
		end
	endtask
	task automatic go(input logic [7:0] fn, input logic [15:0] ad,
		input logic [15:0] vl, input logic er);
		seed = lfsr(seed);
		drive_state = seed[18:9];
		monitor = {seed, ~seed, seed, ~seed, seed[15:0]};
		transact({seed[7:0], fn, ad, vl, er, seed[8]});
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	initial begin
		#100000;
		failures++;
		$display("timeout waiting for the bench to finish");
		results();
	end
	initial begin
		{rst_n, req_valid, rx_activity, monitor_fault} = 4'h0;
		{keypad_clear, slow, req} = '0;
		reply_delay_setting = 11'h000;
		bus_silence_interval_setting = 8'h00;
		drive_state = '0;
		monitor = '0;
		seed = 32'h31f6;
		repeat (4) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge sys_clk);
		transact({8'h01, 8'h06, 16'h2102, 16'h0000, 2'b00});
		transact({8'h01, 8'h06, 16'h2102, 16'h0000, 2'b01});
		$display("done: exception example");
		repeat (12) go(8'h03, 16'h2119, 16'h0001, 1'b0);
		foreach (maddr[i]) go(8'h03, maddr[i], 16'h0001, 1'b0);
		$display("done: status and monitor reads");
		go(8'h03, 16'h2119, 16'h0002, 1'b0);
		go(8'h03, 16'h2201, 16'h0001, 1'b0);
		go(8'h10, 16'h2119, 16'h0001, 1'b0);
		go(8'h06, 16'h2103, 16'h0005, 1'b0);
		monitor_fault = 1'b1;
		go(8'h03, 16'h2103, 16'h0001, 1'b0);
		monitor_fault = 1'b0;
		go(8'h03, 16'h2119, 16'h0001, 1'b1);
		go(8'h06, 16'h2102, 16'h0001, 1'b1);
		$display("done: exceptions and dropped frames");
		reply_delay_setting = 11'h001;
		slow = 1'b1;
		repeat (4) go(8'h03, 16'h2119, 16'h0001, 1'b0);
		go(8'h06, 16'h2105, 16'h0001, 1'b0);
		reply_delay_setting = 11'h000;
		slow = 1'b0;
		$display("done: reply delay with slow master");
		bus_silence_interval_setting = 8'h01;
		rx_activity = 1'b1;
		@(negedge sys_clk);
		rx_activity = 1'b0;
		repeat (20) @(negedge sys_clk);
		check("silence code", 16'h0010, comm_fault_display_code);
		check("silence shown", 16'h0001, comm_fault_active);
		bus_silence_interval_setting = 8'h00;
		keypad_clear = 1'b1;
		@(negedge sys_clk);
		keypad_clear = 1'b0;
		$display("done: bus silence");
		results();
	end
endmodule
`default_nettype wire
